// ===== design/smpf_framer.sv
// smpf_framer.sv: manufacturing package framer with AHB-Lite register slave
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`default_nettype none

module smpf_framer #(
    parameter int HALF_CYC = smpf_pkg::HALF_BIT_CYC,
    parameter int BG_PERIOD = smpf_pkg::BG_PERIOD_CYC
) (
    input wire logic hclk, // system clock, 250 MHz
    input wire logic hresetn, // power-on reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic hresp, // response, always okay
    output logic [31:0] hrdata, // read data
    input wire logic supply_ok, // supply above start-up level
    input wire logic die_slot_bit, // die mount position
    input wire logic ev_mem_pattern_fail, // pulse: memory pattern test failed
    input wire logic ev_prog_sum_fail, // pulse: program checksum failed
    input wire logic ev_param_sum_fail, // pulse: parameter checksum failed
    input wire logic ev_cal_compare_fail, // pulse: calibration copy compare failed
    input wire logic watchdog_fail, // level: watchdog acknowledge error
    input wire logic conv_overflow, // level: converter overflow
    input wire logic conv_underflow, // level: converter underflow
    input wire logic link_not_ready, // level: link not ready
    output logic link_current_high, // modulated supply current
    output logic manuf_busy, // manufacturing packages in progress
    output logic meas_active, // measurement packages may run
    output logic selftest_start, // pulse: run start-up tests
    output logic bg_check_req // pulse: run background tests
);
    typedef struct packed {
        smpf_pkg::smpf_state_t st;
        logic done;
        logic [7:0] pkg_idx;
        logic [2:0] fetch_cnt;
        logic [7:0] rd_addr;
        logic [23:0] bytes;
        logic health;
        logic [2:0] code;
        logic die;
        logic [3:0] cal;
        logic [7:0] total;
        logic [15:0] crc;
        logic [3:0] pend;
        logic waiting;
        logic [1:0] frame_idx;
        logic [12:0] frame;
        logic go;
        logic en;
        logic [7:0] total_reg;
        logic [7:0] waddr;
        logic [15:0] checksum_reg;
        logic [3:0] cal_reg;
        logic a_wr;
        logic [7:0] a_ofs;
        logic [31:0] rdata;
        logic started;
        logic st_req;
        logic bg_req;
        logic [15:0] bg_cnt;
    } smpf_regs_t;

    smpf_regs_t s_reg;
    smpf_regs_t s_next;

    logic mem_we;
    logic [7:0] mem_rdata;
    logic enc_busy;
    logic enc_done;

    // ------------------------------------------------------------
    // parameter table and line encoder
    // ------------------------------------------------------------
    assign mem_we = s_reg.a_wr && (s_reg.a_ofs == smpf_pkg::OFS_WDATA);

    smpf_param_table #(
        .AW(8),
        .DW(8)
    ) u_table (
        .hclk(hclk),
        .hresetn(hresetn),
        .we(mem_we),
        .waddr(s_reg.waddr),
        .wdata(hwdata[7:0]),
        .raddr(s_reg.rd_addr),
        .rdata(mem_rdata)
    );

    smpf_manchester #(
        .HALF_CYC(HALF_CYC)
    ) u_enc (
        .hclk(hclk),
        .hresetn(hresetn),
        .go(s_reg.go),
        .frame(s_reg.frame),
        .current_high(link_current_high),
        .busy(enc_busy),
        .done(enc_done)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] data;
        logic [2:0] fault;
        logic ok;
        logic latch_now;
        logic first;
        logic last;
        logic [3:0] ev;
        s_next = s_reg;
        data = 8'h00;
        fault = smpf_pkg::FAULT_NONE;
        latch_now = 1'b0;
        ok = 1'b1;
        s_next.go = 1'b0;
        s_next.st_req = 1'b0;
        s_next.bg_req = 1'b0;
        first = (s_reg.pkg_idx == 8'h00);
        last = (s_reg.pkg_idx == s_reg.total - 8'h01);
        ev = {ev_cal_compare_fail, ev_param_sum_fail, ev_prog_sum_fail, ev_mem_pattern_fail};

        if (s_reg.pend[2]) begin
            fault = smpf_pkg::FAULT_PARAM_SUM;
        end else if (s_reg.pend[1]) begin
            fault = smpf_pkg::FAULT_PROG_SUM;
        end else if (watchdog_fail) begin
            fault = smpf_pkg::FAULT_WATCHDOG;
        end else if (s_reg.pend[0] || s_reg.pend[3]) begin
            fault = smpf_pkg::FAULT_MEM_CHECK;
        end else if (link_not_ready) begin
            fault = smpf_pkg::FAULT_LINK_NOT_READY;
        end else if (conv_underflow) begin
            fault = smpf_pkg::FAULT_CONV_UNDER;
        end else if (conv_overflow) begin
            fault = smpf_pkg::FAULT_CONV_OVER;
        end
        ok = ~((|s_reg.pend) | watchdog_fail);

        if (!s_reg.started) begin
            s_next.started = 1'b1;
            s_next.st_req = 1'b1;
        end

        case (s_reg.st)
            smpf_pkg::SMPF_IDLE: begin
                if (s_reg.en && supply_ok) begin
                    if (s_reg.done) begin
                        s_next.st = smpf_pkg::SMPF_MEAS;
                    end else begin
                        latch_now = 1'b1;
                    end
                end
            end
            smpf_pkg::SMPF_FETCH: begin
                // read three bytes, highest address first
                s_next.fetch_cnt = s_reg.fetch_cnt + 3'h1;
                if (s_reg.fetch_cnt != 3'h0) begin
                    s_next.bytes = {s_reg.bytes[15:0], mem_rdata};
                end
                if (!first && !last && (s_reg.fetch_cnt < 3'h3)) begin
                    s_next.rd_addr = s_reg.rd_addr - 8'h01;
                end
                if (s_reg.fetch_cnt == 3'h3) begin
                    s_next.st = smpf_pkg::SMPF_SEND;
                    s_next.frame_idx = 2'h0;
                    s_next.waiting = 1'b0;
                end
            end
            smpf_pkg::SMPF_SEND: begin
                if (!s_reg.waiting) begin
                    case (s_reg.frame_idx)
                        2'h0: begin
                            // counter is low bits of index
                            data = {smpf_pkg::FIRST_MARK, s_reg.health, s_reg.pkg_idx[4:0]};
                        end
                        2'h1: begin
                            if (first) begin
                                data = {s_reg.die, s_reg.code, s_reg.cal};
                            end else if (last) begin
                                data = s_reg.crc[15:8];
                            end else begin
                                data = s_reg.bytes[23:16];
                            end
                        end
                        2'h2: begin
                            if (first) begin
                                data = 8'h00;
                            end else if (last) begin
                                data = s_reg.crc[7:0];
                            end else begin
                                data = s_reg.bytes[15:8];
                            end
                        end
                        default: begin
                            // total minus two, zero in the last package, or third byte
                            if (first) begin
                                data = s_reg.total - smpf_pkg::TOTAL_MIN;
                            end else if (last) begin
                                data = 8'h00;
                            end else begin
                                data = s_reg.bytes[7:0];
                            end
                        end
                    endcase
                    s_next.frame = smpf_pkg::smpf_frame(~s_reg.frame_idx, data);
                    s_next.go = 1'b1;
                    s_next.waiting = 1'b1;
                end else if (enc_done) begin
                    s_next.waiting = 1'b0;
                    if (s_reg.frame_idx == smpf_pkg::LAST_FRAME) begin
                        s_next.pkg_idx = s_reg.pkg_idx + 8'h01;
                        // stop at the latched package total, at least TOTAL_MIN
                        if (s_next.pkg_idx == s_reg.total) begin
                            s_next.done = 1'b1;
                            s_next.st = supply_ok ? smpf_pkg::SMPF_MEAS : smpf_pkg::SMPF_IDLE;
                        end else if (supply_ok) begin
                            latch_now = 1'b1;
                        end else begin
                            s_next.st = smpf_pkg::SMPF_IDLE;
                        end
                    end else begin
                        s_next.frame_idx = s_reg.frame_idx + 2'h1;
                    end
                end
            end
            default: begin
                // background checks while measuring
                // no request in the cycle that leaves measurement
                if (!supply_ok) begin
                    s_next.st = smpf_pkg::SMPF_IDLE;
                end else if (s_reg.bg_cnt == 16'(BG_PERIOD - 1)) begin
                    s_next.bg_cnt = 16'h0000;
                    s_next.bg_req = 1'b1;
                end else begin
                    s_next.bg_cnt = s_reg.bg_cnt + 16'h0001;
                end
            end
        endcase

        if (latch_now) begin
            s_next.st = smpf_pkg::SMPF_FETCH;
            s_next.fetch_cnt = 3'h0;
            s_next.health = ok;
            s_next.code = fault;
            // die slot captured with the package
            s_next.die = die_slot_bit;
            s_next.cal = s_reg.cal_reg;
            s_next.crc = s_reg.checksum_reg;
            if (s_next.pkg_idx == 8'h00) begin
                s_next.total = (s_reg.total_reg < smpf_pkg::TOTAL_MIN) ?
                               smpf_pkg::TOTAL_MIN : s_reg.total_reg;
            end
        end
        // memory fail reported once, then cleared
        // set wins over the clear at latch
        s_next.pend = ev | (s_reg.pend & ~{4{latch_now}});

        // bus data phase: register writes
        if (s_reg.a_wr) begin
            if (s_reg.a_ofs == smpf_pkg::OFS_CTRL) begin
                s_next.en = hwdata[0];
            end else if (s_reg.a_ofs == smpf_pkg::OFS_TOTAL) begin
                s_next.total_reg = hwdata[7:0];
            end else if (s_reg.a_ofs == smpf_pkg::OFS_WADDR) begin
                s_next.waddr = hwdata[7:0];
            end else if (s_reg.a_ofs == smpf_pkg::OFS_WDATA) begin
                s_next.waddr = s_reg.waddr + 8'h01;
            end else if (s_reg.a_ofs == smpf_pkg::OFS_CHECKSUM) begin
                s_next.checksum_reg = hwdata[15:0];
            end else if (s_reg.a_ofs == smpf_pkg::OFS_INFO) begin
                s_next.cal_reg = hwdata[3:0];
            end
        end

        // bus address phase: capture and prepare read data
        s_next.a_wr = 1'b0;
        if (hsel && hready && htrans[1]) begin
            s_next.a_wr = hwrite && (hsize == smpf_pkg::HSIZE_WORD);
            s_next.a_ofs = haddr[7:0];
            if (haddr[7:0] == smpf_pkg::OFS_CTRL) begin
                s_next.rdata = {31'h0, s_reg.en};
            end else if (haddr[7:0] == smpf_pkg::OFS_TOTAL) begin
                s_next.rdata = {24'h0, s_reg.total_reg};
            end else if (haddr[7:0] == smpf_pkg::OFS_WADDR) begin
                s_next.rdata = {24'h0, s_reg.waddr};
            end else if (haddr[7:0] == smpf_pkg::OFS_CHECKSUM) begin
                s_next.rdata = {16'h0, s_reg.checksum_reg};
            end else if (haddr[7:0] == smpf_pkg::OFS_INFO) begin
                s_next.rdata = {28'h0, s_reg.cal_reg};
            end else if (haddr[7:0] == smpf_pkg::OFS_STATUS) begin
                s_next.rdata = {14'h0, s_reg.st, s_reg.pkg_idx, 3'h0, s_reg.done, ok, fault};
            end else begin
                s_next.rdata = 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
            s_reg.total_reg <= smpf_pkg::TOTAL_RST;
            s_reg.total <= smpf_pkg::TOTAL_RST;
            s_reg.rd_addr <= smpf_pkg::TABLE_TOP;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_reg.rdata;
    assign manuf_busy = (s_reg.st == smpf_pkg::SMPF_FETCH) || (s_reg.st == smpf_pkg::SMPF_SEND);
    assign meas_active = (s_reg.st == smpf_pkg::SMPF_MEAS);
    assign selftest_start = s_reg.st_req;
    assign bg_check_req = s_reg.bg_req;
endmodule

`default_nettype wire

// ===== design/smpf_pkg.sv
// smpf_pkg.sv: constants, types and frame helper for the manufacturing package framer
`default_nettype none

package smpf_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TOTAL = 8'h04;
    localparam logic [7:0] OFS_WADDR = 8'h08;
    localparam logic [7:0] OFS_WDATA = 8'h0C;
    localparam logic [7:0] OFS_CHECKSUM = 8'h10;
    localparam logic [7:0] OFS_INFO = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ------------------------------------------------------------
    // reset values and table layout
    // ------------------------------------------------------------
    localparam logic [7:0] TOTAL_RST = 8'h05;
    localparam logic [7:0] TOTAL_MIN = 8'h02;
    localparam logic [7:0] TABLE_TOP = 8'h5B;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int BIT_TIME_NS = 8000;
    localparam int HALF_BIT_CYC = (BIT_TIME_NS / 2) / CLK_PERIOD_NS;
    localparam int BG_PERIOD_CYC = 1000;

    // ------------------------------------------------------------
    // frame fields
    // ------------------------------------------------------------
    localparam logic [1:0] START_PAIR = 2'h0;
    localparam logic [1:0] FIRST_MARK = 2'h1;
    localparam logic [1:0] LAST_FRAME = 2'h3;

    localparam logic [2:0] FAULT_NONE = 3'h0;
    localparam logic [2:0] FAULT_CONV_OVER = 3'h1;
    localparam logic [2:0] FAULT_CONV_UNDER = 3'h2;
    localparam logic [2:0] FAULT_LINK_NOT_READY = 3'h3;
    localparam logic [2:0] FAULT_MEM_CHECK = 3'h4;
    localparam logic [2:0] FAULT_WATCHDOG = 3'h5;
    localparam logic [2:0] FAULT_PROG_SUM = 3'h6;
    localparam logic [2:0] FAULT_PARAM_SUM = 3'h7;

    typedef enum logic [1:0] {
        SMPF_IDLE = 2'h0,
        SMPF_FETCH = 2'h1,
        SMPF_SEND = 2'h3,
        SMPF_MEAS = 2'h2
    } smpf_state_t;

    // start pair, label, data byte, odd parity over bits 12..1
    function automatic logic [12:0] smpf_frame(input logic [1:0] frame_label,
                                               input logic [7:0] data);
        smpf_frame = {START_PAIR, frame_label, data, ~^{START_PAIR, frame_label, data}};
    endfunction
endpackage

`default_nettype wire

// ===== design/smpf_param_table.sv
// smpf_param_table.sv: byte table of stored parameters with registered read data
`default_nettype none

module smpf_param_table #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    input wire logic we, // write strobe
    input wire logic [AW-1:0] waddr, // write address
    input wire logic [DW-1:0] wdata, // write data
    input wire logic [AW-1:0] raddr, // read address
    output logic [DW-1:0] rdata // read data, one cycle after raddr
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge hclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule

`default_nettype wire

// ===== design/smpf_manchester.sv
// smpf_manchester.sv: serialises one 13-bit frame onto the current-modulated line
`default_nettype none

module smpf_manchester #(
    parameter int HALF_CYC = smpf_pkg::HALF_BIT_CYC
) (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    input wire logic go, // pulse: start a frame
    input wire logic [12:0] frame, // frame, bit 12 goes first
    output logic current_high, // high supply current level
    output logic busy, // frame in progress
    output logic done // pulse: frame finished
);
    typedef struct packed {
        logic busy;
        logic half;
        logic [3:0] left;
        logic [15:0] cnt;
        logic [12:0] sh;
        logic line;
        logic done;
    } smpf_enc_t;

    smpf_enc_t s_reg;
    smpf_enc_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        if (!s_reg.busy) begin
            if (go) begin
                s_next.busy = 1'b1;
                s_next.half = 1'b0;
                s_next.left = 4'hC;
                s_next.cnt = 16'h0000;
                s_next.sh = frame;
                s_next.line = frame[12];
            end
        end else if (s_reg.cnt == 16'(HALF_CYC - 1)) begin
            s_next.cnt = 16'h0000;
            if (!s_reg.half) begin
                s_next.half = 1'b1;
                s_next.line = ~s_reg.sh[12];
            end else if (s_reg.left == 4'h0) begin
                s_next.busy = 1'b0;
                s_next.half = 1'b0;
                s_next.line = 1'b0;
                s_next.done = 1'b1;
            end else begin
                s_next.half = 1'b0;
                s_next.left = s_reg.left - 4'h1;
                s_next.sh = {s_reg.sh[11:0], 1'b0};
                s_next.line = s_reg.sh[11];
            end
        end else begin
            s_next.cnt = s_reg.cnt + 16'h0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign current_high = s_reg.line;
    assign busy = s_reg.busy;
    assign done = s_reg.done;
endmodule

`default_nettype wire

// ===== verif/smpf_framer_chk.sv
// smpf_framer_chk.sv: port assertions for the package framer
`default_nettype none

module smpf_framer_chk (
    input wire logic hclk, // clock
    input wire logic hresetn, // reset, active low
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic link_current_high, // line level
    input wire logic manuf_busy, // packages running
    input wire logic meas_active, // measurement phase
    input wire logic selftest_start, // start-up tests
    input wire logic bg_check_req // background tests
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_hold; $stable(link_current_high); endsequence
    sequence s_quiet; !link_current_high [*4]; endsequence
    property p_bus; hreadyout && !hresp; endproperty
    a_bus: assert property (p_bus) else $error("bus not ready or error");
    property p_half; $changed(link_current_high) |=> s_hold; endproperty
    a_half: assert property (p_half) else $error("half bit too short");
    property p_fetch; $rose(manuf_busy) |-> s_quiet; endproperty
    a_fetch: assert property (p_fetch) else $error("line active in fetch");
    property p_idle; meas_active && $past(meas_active, 4) |-> !link_current_high; endproperty
    a_idle: assert property (p_idle) else $error("line active after packages");
    property p_excl; !(manuf_busy && meas_active); endproperty
    a_excl: assert property (p_excl) else $error("busy and measuring");
    property p_nomanuf; meas_active |=> !manuf_busy; endproperty
    a_nomanuf: assert property (p_nomanuf) else $error("packages restarted");
    property p_st; selftest_start |=> !selftest_start; endproperty
    a_st: assert property (p_st) else $error("self-test pulse too long");
    property p_bg; bg_check_req |-> meas_active ##1 !bg_check_req [*8]; endproperty
    a_bg: assert property (p_bg) else $error("background request misplaced");
endmodule

bind smpf_framer smpf_framer_chk i_smpf_framer_chk (.hclk, .hresetn, .hreadyout, .hresp,
    .link_current_high, .manuf_busy, .meas_active, .selftest_start, .bg_check_req);

`default_nettype wire

// ===== verif/smpf_ecu_rx.sv
// smpf_ecu_rx.sv: receiver model that rebuilds frames from the modulated line
`default_nettype none

module smpf_ecu_rx #(
    parameter int HALF = 2
) (
    input wire logic hclk, // clock
    input wire logic link_current_high // modulated line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [12:0] frames[$];
    logic [12:0] f;
    int lost = 0;
    // first half level is the bit
    always begin
        @(posedge link_current_high);
        f = 13'h0000;
        repeat (HALF + 1) @(negedge hclk);
        for (int k = 11; k >= 0; k--) begin
            f[k] = link_current_high;
            repeat (2 * HALF) @(negedge hclk);
        end
        // counter of a first frame orders the table
        if (f[10:9] == 2'b11 && f[5:1] !== 5'(frames.size() / 4)) lost++;
        frames.push_back(f);
    end
endmodule

`default_nettype wire

// ===== verif/test_sensor_manufacturing_package_framer.sv
// test_sensor_manufacturing_package_framer.sv: bus and frame tests for the framer
`default_nettype none

module test_sensor_manufacturing_package_framer;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, supply_ok = 1'b0, die_slot_bit = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [1:0] htrans = 2'h0;
    logic [3:0] ev = 4'h0, lv = 4'h0;
    logic hreadyout, hresp, link_current_high, manuf_busy, meas_active;
    int bad_count = 0, checks_done = 0;
    always #2 hclk = ~hclk;
    smpf_framer #(.HALF_CYC(2), .BG_PERIOD(20)) i_smpf_framer (.hclk, .hresetn, .hsel(1'b1),
        .haddr, .htrans, .hwrite, .hsize(smpf_pkg::HSIZE_WORD), .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .supply_ok, .die_slot_bit, .ev_mem_pattern_fail(ev[0]),
        .ev_prog_sum_fail(ev[1]), .ev_param_sum_fail(ev[2]), .ev_cal_compare_fail(ev[3]),
        .watchdog_fail(lv[0]), .conv_overflow(lv[1]), .conv_underflow(lv[2]),
        .link_not_ready(lv[3]), .link_current_high, .manuf_busy, .meas_active,
        .selftest_start(), .bg_check_req());
    smpf_ecu_rx #(.HALF(2)) i_smpf_ecu_rx (.hclk, .link_current_high);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    function automatic logic [12:0] fr(input logic [1:0] l, input logic [7:0] d);
        fr = {2'b00, l, d, ~(^{l, d})};
    endfunction
    task automatic run(input logic [2:0] c);
        logic [7:0] d[12];
        logic h0, h1;
        h0 = c < 3'h4;
        h1 = c != 3'h5;
        hresetn <= 1'b0;
        lv <= {c == 3'h3, c == 3'h2, c == 3'h1, c == 3'h5};
        die_slot_bit <= c[0];
        supply_ok <= 1'b1;
        i_smpf_ecu_rx.frames.delete();
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ev <= (c == 3'h4) ? 4'h1 : (c == 3'h6) ? 4'h2 : (c == 3'h7) ? 4'h4 : 4'h0;
        xfer(1'b0, smpf_pkg::OFS_TOTAL, 32'h0);
        ev <= 4'h0;
        chk("total", {24'h0, smpf_pkg::TOTAL_RST}, r);
        xfer(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, r);
        xfer(1'b1, smpf_pkg::OFS_WADDR, 32'h59);
        for (int i = 0; i < 3; i++) xfer(1'b1, smpf_pkg::OFS_WDATA, 32'h11 * (i + 1));
        xfer(1'b1, smpf_pkg::OFS_INFO, {28'h0, 1'b1, c});
        xfer(1'b1, smpf_pkg::OFS_CHECKSUM, 32'hBEEF);
        xfer(1'b1, smpf_pkg::OFS_TOTAL, 32'h3);
        xfer(1'b1, smpf_pkg::OFS_CTRL, 32'h1);
        for (int i = 0; i < 4000 && meas_active !== 1'b1; i++) @(posedge hclk);
        d = '{{2'b01, h0, 5'h00}, {c[0], c, 1'b1, c}, 8'h00, 8'h01, {2'b01, h1, 5'h01},
            8'h33, 8'h22, 8'h11, {2'b01, h1, 5'h02}, 8'hBE, 8'hEF, 8'h00};
        chk("frame count", 32'd12, i_smpf_ecu_rx.frames.size());
        for (int i = 0; i < 12; i++)
            chk("frame", fr(2'(3 - i % 4), d[i]), i_smpf_ecu_rx.frames[i]);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        @(posedge hclk);
        for (int i = 0; i < 8; i++) run(3'(i));
        supply_ok <= 1'b0;
        repeat (50) @(posedge hclk);
        supply_ok <= 1'b1;
        repeat (300) @(posedge hclk);
        chk("resent frames", 32'd12, i_smpf_ecu_rx.frames.size());
        chk("measuring", 32'h1, {31'h0, meas_active});
        xfer(1'b0, smpf_pkg::OFS_STATUS, 32'h0);
        chk("status", 32'h0002_0318, r);
        chk("package order", 32'h0, i_smpf_ecu_rx.lost);
        give_verdict();
    end
    initial begin
        repeat (30000) @(posedge hclk);
        bad_count++;
        give_verdict();
    end
endmodule

`default_nettype wire
